//--- hdl/sac_dev.sv
// sac_dev: converter end, conversion framing and power modes
// assumes: runs on the link clock and on the select fall edge; select is launched by the host
// in step with the serial clock, so it is a link-domain signal
`timescale 1ns/100ps

module sac_dev (
  sac_link_if.dev           lnk,
  input  wire logic         rst,
  input  wire logic [11:0]  sample_in,
  output logic              shutdown,
  output logic              dummy_frame,
  output logic              tracking,
  output logic              frame_busy
);

  // ----------------------------------------
  // frame clear
  // ----------------------------------------
  logic        frame_clr;
  logic [4:0]  count_q;
  logic [4:0]  count_d;
  logic        shutdown_q;
  logic        warm_q;
  logic        dummy_q;
  logic [11:0] sample_q;
  logic        rise_seen_q;
  logic        out_q;
  logic [15:0] frame_w;
  logic [3:0]  bit_idx;

  // select high aborts the frame at once, with no clock needed
  assign frame_clr = rst | lnk.cs_n;

  // ----------------------------------------
  // fall counter
  // ----------------------------------------
  // next fall number; saturates at the frame end
  always_comb begin
    if (count_q == sac_pkg::FRAME_END) begin
      count_d = count_q;
    end else begin
      count_d = 5'(count_q + 5'h01);
    end
  end

  // counts falls since select fell, held at zero while select is high
  always_ff @(negedge lnk.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------
  // power mode
  // ----------------------------------------
  // fall 2 arms shutdown; fall 10 keeps normal; earlier rise leaves mode
  always_ff @(negedge lnk.sclk or posedge rst) begin
    if (rst) begin
      shutdown_q <= sac_pkg::PWRUP_SHDN;
    end else if (!lnk.cs_n && count_q != sac_pkg::FRAME_END) begin
      if (count_d == sac_pkg::SHDN_FALL) begin
        shutdown_q <= 1'b1;
      end else if (count_d == sac_pkg::NORM_FALL) begin
        shutdown_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // warm-up tracking
  // ----------------------------------------
  // a frame starting cold or from shutdown is a dummy
  always_ff @(negedge lnk.sclk or posedge rst) begin
    if (rst) begin
      dummy_q <= 1'b1;
      warm_q  <= 1'b0;
    end else if (!lnk.cs_n && count_q != sac_pkg::FRAME_END) begin
      if (count_d == sac_pkg::FIRST_FALL) begin
        dummy_q <= shutdown_q | ~warm_q;
        warm_q  <= warm_q & ~shutdown_q;
      end else if (count_d == sac_pkg::FRAME_END) begin
        warm_q  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // track and hold
  // ----------------------------------------
  // select fall freezes the input and starts the conversion
  always_ff @(negedge lnk.cs_n or posedge rst) begin
    if (rst) begin
      sample_q <= 12'h000;
    end else begin
      sample_q <= sample_in;
    end
  end

  // thirteenth rise hands the capacitor back to the input
  always_ff @(posedge lnk.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      rise_seen_q <= 1'b0;
    end else if (count_q == sac_pkg::TRACK_RISE) begin
      rise_seen_q <= 1'b1;
    end
  end

  // hold from select fall to the thirteenth rise; an aborted frame tracks again
  assign tracking = lnk.cs_n | rise_seen_q;

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  // word layout: leading zeros then result, msb first
  assign frame_w = {sac_pkg::LEAD_ZEROS, sample_q};
  assign bit_idx = 4'(5'h0f - count_d);

  // fall k presents frame bit k; bit 0 stands from select fall
  always_ff @(negedge lnk.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      out_q <= 1'b0;
    end else if (count_d != sac_pkg::FRAME_END) begin
      out_q <= frame_w[bit_idx];
    end else begin
      out_q <= 1'b0;
    end
  end

  // drive only inside a live frame; floats at fall 16 or select rise
  assign frame_busy     = ~frame_clr & (count_q != sac_pkg::FRAME_END);
  assign lnk.serial_oe  = frame_busy;
  assign lnk.serial_out = out_q;

  // ----------------------------------------
  // status
  // ----------------------------------------
  assign shutdown    = shutdown_q;
  assign dummy_frame = dummy_q;

endmodule

//--- hdl/sac_host.sv
// sac_host: host end, frame sequencer with result fifo
// assumes: ref_clk domain; makes the serial clock by division
`timescale 1ns/100ps

// ----------------------------------------
// result fifo
// ----------------------------------------
module sac_fifo #(
  parameter int unsigned W = 12,
  parameter int unsigned D = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];

  // storage
  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// sequencer
// ----------------------------------------
module sac_host (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  sac_link_if.host          lnk,
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire sac_pkg::sac_cmd_t cmd,
  output logic              res_valid,
  input  wire logic         res_ready,
  output logic [11:0]       res_data,
  output logic              dummy_pending
);

  sac_pkg::sac_hstate_t st_q;
  sac_pkg::sac_cmd_t    cmd_q;
  logic [7:0]  tmr_q;
  logic [4:0]  falls_q;
  logic [4:0]  end_q;
  logic [15:0] shreg_q;
  logic        cs_n_q;
  logic        sclk_q;
  logic        dummy_q;
  logic        sd_m_q;
  logic        sd_q;
  logic        push;
  logic        fifo_ready;
  logic [11:0] word;

  // data pin crosses from the link into ref_clk
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sd_m_q <= 1'b0;
      sd_q   <= 1'b0;
    end else begin
      sd_m_q <= lnk.serial_out;
      sd_q   <= sd_m_q;
    end
  end

  // one word slot is reserved before a frame starts
  assign cmd_ready = (st_q == sac_pkg::H_IDLE) && fifo_ready;

  // frame sequencer, serial clock idles high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q    <= sac_pkg::H_IDLE;
      cmd_q   <= sac_pkg::CMD_READ;
      tmr_q   <= 8'h00;
      falls_q <= 5'h00;
      end_q   <= sac_pkg::END_READ;
      shreg_q <= 16'h0000;
      cs_n_q  <= 1'b1;
      sclk_q  <= 1'b1;
    end else begin
      unique case (st_q)
        sac_pkg::H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_q   <= cmd;
            end_q   <= (cmd == sac_pkg::CMD_SLEEP) ? sac_pkg::END_SLEEP :
                       (cmd == sac_pkg::CMD_QUICK) ? sac_pkg::END_QUICK :
                                                     sac_pkg::END_READ;
            cs_n_q  <= 1'b0;
            falls_q <= 5'h00;
            tmr_q   <= 8'(sac_pkg::HALF_CYC - 8'h01);
            st_q    <= sac_pkg::H_SETUP;
          end
        end
        sac_pkg::H_SETUP, sac_pkg::H_HI: begin
          if (tmr_q == 8'h00) begin
            shreg_q <= {shreg_q[14:0], sd_q}; // bit read before each fall
            sclk_q  <= 1'b0;
            falls_q <= 5'(falls_q + 5'h01);
            tmr_q   <= 8'(sac_pkg::HALF_CYC - 8'h01);
            st_q    <= sac_pkg::H_LO;
          end else begin
            tmr_q <= 8'(tmr_q - 8'h01);
          end
        end
        sac_pkg::H_LO: begin
          if (tmr_q == 8'h00) begin
            sclk_q <= 1'b1;
            tmr_q  <= 8'(sac_pkg::HALF_CYC - 8'h01);
            if (falls_q == end_q) begin
              cs_n_q <= 1'b1;
              tmr_q  <= sac_pkg::GAP_CYC;
              st_q   <= sac_pkg::H_GAP;
            end else begin
              st_q <= sac_pkg::H_HI;
            end
          end else begin
            tmr_q <= 8'(tmr_q - 8'h01);
          end
        end
        sac_pkg::H_GAP: begin
          if (tmr_q == 8'h00) begin
            st_q <= sac_pkg::H_IDLE;
          end else begin
            tmr_q <= 8'(tmr_q - 8'h01);
          end
        end
        default: begin
          st_q   <= sac_pkg::H_IDLE;
          cs_n_q <= 1'b1;
          sclk_q <= 1'b1;
        end
      endcase
    end
  end

  // a cold start or a sleep frame makes the next frame a dummy
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dummy_q <= 1'b1;
    end else if (st_q == sac_pkg::H_LO && tmr_q == 8'h00 && falls_q == end_q) begin
      dummy_q <= (cmd_q == sac_pkg::CMD_SLEEP) | (dummy_q & (end_q != sac_pkg::END_READ));
    end
  end

  // full word uses bits 4..15; a cut word keeps its top bits
  assign word = (end_q == sac_pkg::END_READ) ? shreg_q[11:0] : {shreg_q[7:0], 4'h0};
  assign push = (st_q == sac_pkg::H_LO) && (tmr_q == 8'h00) && (falls_q == end_q) &&
                (cmd_q != sac_pkg::CMD_SLEEP) && !dummy_q;

  sac_fifo #(
    .W (sac_pkg::DATA_W),
    .D (sac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (word),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign lnk.cs_n      = cs_n_q;
  assign lnk.sclk      = sclk_q;
  assign dummy_pending = dummy_q;

endmodule

//--- hdl/sac_link_if.sv
// sac_link_if: the three-wire link between host and converter
// assumes: host drives select and clock, converter drives data with enable
`timescale 1ns/100ps

interface sac_link_if;
  logic cs_n;         // conversion select, active low
  logic sclk;         // serial clock, made by the host, idles high
  logic serial_out;   // converter data
  logic serial_oe;    // high while converter drives data

  modport dev (
    input  cs_n,
    input  sclk,
    output serial_out,
    output serial_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input  serial_out,
    input  serial_oe
  );
endinterface

//--- hdl/sac_pkg.sv
// sac_pkg: shared constants and types for the serial converter link
// assumes: both ends and the bench refer to it as sac_pkg::name
package sac_pkg;

  // ----------------------------------------
  // frame geometry, counted in serial clock falls
  // ----------------------------------------
  localparam int unsigned FRAME_FALLS = 16;          // data floats at this fall
  localparam logic [4:0]  FRAME_END   = 5'h10;       // same figure as a count
  localparam logic [4:0]  SHDN_FALL   = 5'h02;       // first fall that arms shutdown
  localparam logic [4:0]  NORM_FALL   = 5'h0a;       // fall that keeps normal mode
  localparam logic [4:0]  TRACK_RISE  = 5'h0d;       // rise that returns to track
  localparam logic [4:0]  FIRST_FALL  = 5'h01;
  localparam logic [3:0]  LEAD_ZEROS  = 4'h0;        // bits ahead of the result
  localparam int unsigned DATA_W      = 12;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam logic        PWRUP_SHDN  = 1'b0;        // mode at power-up, either is legal

  // ----------------------------------------
  // host frame lengths per command
  // ----------------------------------------
  localparam logic [4:0]  END_READ    = 5'h10;       // full word
  localparam logic [4:0]  END_SLEEP   = 5'h04;       // abort inside the shutdown window
  localparam logic [4:0]  END_QUICK   = 5'h0c;       // cut after fall 10, before fall 15

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned REF_PERIOD_NS = 50;        // ref_clk at 20 MHz
  localparam int unsigned QUIET_NS      = 50;
  localparam int unsigned ACQ_NS        = 400;
  localparam int unsigned QUIET_CYC     = (QUIET_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int unsigned ACQ_CYC       = (ACQ_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [7:0]  GAP_CYC       = 8'((QUIET_CYC > ACQ_CYC) ? QUIET_CYC : ACQ_CYC);
  localparam logic [7:0]  HALF_CYC      = 8'h03;     // ref_clk cycles per serial clock half

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_READ  = 2'h0,
    CMD_SLEEP = 2'h1,
    CMD_QUICK = 2'h2
  } sac_cmd_t;

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_SETUP = 5'h02,
    H_LO    = 5'h04,
    H_HI    = 5'h08,
    H_GAP   = 5'h10
  } sac_hstate_t;

endpackage

//--- verif/sac_link_checker.sv
// sac_link_checker: framing and timing checks on the three-wire link
// assumes: placed beside the link interface; ref_clk samples every wire
`timescale 1ns/100ps

module sac_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic serial_oe
);
  logic       sclk_q;
  logic       fall_now;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // helper: serial clock falls in this frame
  // ----------------------------------------
  assign fall_now = sclk_q & ~sclk;
  assign cnt_d    = cnt_q + {4'h0, fall_now};

  // last sampled serial clock level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  // fall count, held at zero while deselected
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cs_n ? 5'h00 : cnt_d;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence sel_fall;
    $fell(cs_n);
  endsequence
  sequence clk_hold_hi;
    sclk [*3];
  endsequence

  setup_idle_a: assert property (sel_fall |-> clk_hold_hi)
    else $error("serial clock fell too soon after select");
  data_drive_a: assert property (!cs_n && cnt_d < 5'h10 |-> serial_oe)
    else $error("data not driven inside frame");
  data_float_a: assert property (cnt_d == 5'h10 |-> !serial_oe)
    else $error("data driven after the last fall");
  desel_float_a: assert property (cs_n |-> !serial_oe)
    else $error("data driven while deselected");
  lead_zeros_a: assert property (serial_oe && cnt_d < 5'h04 |-> !serial_out)
    else $error("leading bits not zero");
  frame_cut_a: assert property ($rose(cs_n) |-> cnt_q inside {5'h04, 5'h0c, 5'h10})
    else $error("select raised at an unplanned fall");
  max_falls_a: assert property (cnt_d <= 5'h10)
    else $error("more than sixteen falls in a frame");
  quiet_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("gap between frames too short");
  half_low_a: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("serial clock low phase wrong");
  idle_clock_a: assert property (cs_n |-> sclk)
    else $error("serial clock not idle high");
endmodule

//--- verif/test_serial_adc_power_conversion_ctrl.sv
// test_serial_adc_power_conversion_ctrl: host and converter joined by the link
// assumes: sac_pkg, sac_link_if, sac_host, sac_dev and the checker compiled first
`timescale 1ns/100ps

module test_serial_adc_power_conversion_ctrl;
  logic              ref_clk;
  logic              rst;
  logic              cmd_valid;
  logic              cmd_ready;
  sac_pkg::sac_cmd_t cmd;
  logic              res_valid;
  logic              res_ready;
  logic [11:0]       res_data;
  logic              dummy_pending;
  logic [11:0]       sample_in;
  logic              shutdown;
  logic              dummy_frame;
  logic              tracking;
  logic              frame_busy;
  int                n_mismatch;
  int                cmp_count;

  sac_link_if lnk ();

  sac_host i_sac_host (.ref_clk(ref_clk), .rst(rst), .lnk(lnk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .dummy_pending(dummy_pending));
  sac_dev i_sac_dev (.lnk(lnk), .rst(rst), .sample_in(sample_in), .shutdown(shutdown),
    .dummy_frame(dummy_frame), .tracking(tracking), .frame_busy(frame_busy));
  sac_link_checker i_sac_link_checker (.ref_clk(ref_clk), .rst(rst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .serial_out(lnk.serial_out), .serial_oe(lnk.serial_oe));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) fail(msg);
  endtask

  // ----------------------------------------
  // drivers, all entered at a falling edge
  // ----------------------------------------
  task automatic send_cmd(input sac_pkg::sac_cmd_t c);
    int i;
    cmd = c;
    cmd_valid = 1'b1;
    for (i = 0; i < 400 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    if (cmd_ready !== 1'b1) begin
      fail("command not taken");
      stop_test();
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask

  // one frame: sample held from before select falls
  task automatic run_frame(input sac_pkg::sac_cmd_t c, input logic [11:0] s);
    int   i;
    logic trk_seen;
    trk_seen = 1'b0;
    sample_in = s;
    send_cmd(c);
    repeat (6) @(negedge ref_clk);
    chk1(tracking, 1'b0, "tracking inside frame");
    chk1(frame_busy, 1'b1, "data idle inside frame");
    for (i = 0; i < 200 && lnk.cs_n !== 1'b1; i++) begin
      @(negedge ref_clk);
      if (tracking === 1'b1 && lnk.cs_n === 1'b0) trk_seen = 1'b1;
    end
    if (lnk.cs_n !== 1'b1) begin
      fail("frame did not end");
      stop_test();
    end
    chk1(trk_seen, c == sac_pkg::CMD_READ, "track return at wrong rise");
    chk1(lnk.serial_oe, 1'b0, "data driven after frame");
  endtask

  task automatic get_res(input logic [11:0] exp);
    int i;
    res_ready = 1'b1;
    for (i = 0; i < 50 && res_valid !== 1'b1; i++) @(negedge ref_clk);
    chk1(res_valid, 1'b1, "no result word");
    if (res_valid !== 1'b1) stop_test();
    chk12(res_data, exp, "result word wrong");
    @(negedge ref_clk);
    res_ready = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic no_res();
    repeat (4) @(negedge ref_clk);
    chk1(res_valid, 1'b0, "dummy word delivered");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_up();
    chk1(dummy_pending, 1'b1, "no dummy pending at start");
    chk1(dummy_frame, 1'b1, "no dummy frame at start");
    chk1(shutdown, sac_pkg::PWRUP_SHDN, "start mode");
    run_frame(sac_pkg::CMD_READ, 12'h3c5);
    no_res();
    chk1(tracking, 1'b1, "not tracking after frame");
    chk1(dummy_pending, 1'b0, "still warming");
    run_frame(sac_pkg::CMD_READ, 12'ha5a);
    get_res(12'ha5a);
    chk1(dummy_frame, 1'b0, "valid frame marked dummy");
  endtask

  task automatic t_quick();
    run_frame(sac_pkg::CMD_QUICK, 12'hf3c);
    get_res(12'hf30);
    chk1(shutdown, 1'b0, "short frame left normal mode");
    run_frame(sac_pkg::CMD_READ, 12'h9c3);
    get_res(12'h9c3);
  endtask

  task automatic t_sleep();
    run_frame(sac_pkg::CMD_SLEEP, 12'h123);
    no_res();
    chk1(shutdown, 1'b1, "abort did not shut down");
    chk1(dummy_pending, 1'b1, "no dummy after shutdown");
    run_frame(sac_pkg::CMD_SLEEP, 12'h456);
    chk1(shutdown, 1'b1, "early abort left shutdown");
    run_frame(sac_pkg::CMD_READ, 12'h789);
    no_res();
    chk1(dummy_frame, 1'b1, "wake frame not dummy");
    chk1(shutdown, 1'b0, "full frame kept shutdown");
    run_frame(sac_pkg::CMD_READ, 12'hbcd);
    get_res(12'hbcd);
  endtask

  // fill the result buffer, see commands refused, then drain it
  task automatic t_fifo();
    int   i;
    logic busy_seen;
    busy_seen = 1'b0;
    for (i = 0; i < 8; i++) run_frame(sac_pkg::CMD_READ, 12'h0a5 + 12'(i) * 12'h111);
    cmd = sac_pkg::CMD_READ;
    cmd_valid = 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge ref_clk);
      if (cmd_ready !== 1'b0) busy_seen = 1'b1;
    end
    chk1(busy_seen, 1'b0, "command taken with buffer full");
    cmd_valid = 1'b0;
    for (i = 0; i < 8; i++) get_res(12'h0a5 + 12'(i) * 12'h111);
    no_res();
  endtask

  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b0;
    #1;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = sac_pkg::CMD_READ;
    res_ready = 1'b0;
    sample_in = 12'h000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_power_up();
    t_quick();
    t_sleep();
    t_fifo();
    stop_test();
  end
endmodule
